// ==== test/flash_device_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module flash_device_model import flash_status_pkg::*; #(
  parameter logic [7:0] ARRAY_BYTE = 8'h3C,       // stored byte everywhere
  parameter logic [2:0] ERASE_SECTOR = 3'h2       // sector chosen for erase
) (
  input wire logic [ADDR_W-1:0] flashAddr,        // address pins
  input wire logic [DATA_W-1:0] flashDataOut,     // host data
  input wire logic flashCe_b,                     // chip enable
  input wire logic flashOe_b,                     // output enable
  input wire logic flashWe_b,                     // write enable
  input wire logic arm,                           // rise starts an operation
  input wire logic [7:0] busyReads,               // reads until done
  input wire logic failMode,                      // operation hangs
  input wire logic eraseMode,                     // erase, not program
  output logic [DATA_W-1:0] flashDataIn,          // data seen by host
  output logic resetSeen                          // reset command taken
);
  logic [7:0] cnt;
  logic tog;
  logic failing;
  logic busy;
  logic inSect;

  initial begin
    cnt = 8'h00;
    tog = 1'b0;
    failing = 1'b0;
    resetSeen = 1'b0;
  end

  always @(posedge arm) begin
    cnt = busyReads;
    failing = failMode;
    resetSeen = 1'b0;
  end

  // the operation finishes after busyReads completed reads
  // ce_b rises in the same step as oe_b, so testing it here would race
  always @(posedge flashOe_b) begin
    tog = ~tog;
    if (cnt != 8'h00) cnt = cnt - 8'h01;
  end

  always @(posedge flashWe_b) begin
    if (flashDataOut == 8'hF0) begin
      failing = 1'b0;
      cnt = 8'h00;
      resetSeen = 1'b1;
    end
  end

  assign busy = failing || (cnt != 8'h00);
  assign inSect = (flashAddr[18:16] == ERASE_SECTOR);

  // a released bus shows a moving pattern so a stale sample cannot pass
  always @* begin
    if (flashCe_b || flashOe_b) flashDataIn = 8'h5A ^ {8{tog}};
    else if (!busy || (eraseMode && !inSect)) flashDataIn = ARRAY_BYTE;
    // window already closed
    else if (eraseMode) flashDataIn = {1'b0, tog, 3'b001, tog, 2'b00};
    else flashDataIn = {~ARRAY_BYTE[7], tog, failing, 5'b00000};
  end
endmodule : flash_device_model

`default_nettype wire

// ==== test/flash_status_checker.sv ====
`timescale 1ns/100ps
`default_nettype none

module flash_status_checker import flash_status_pkg::*; (
  input wire logic clk_sys,                       // clock
  input wire logic rst_b,                         // reset, low
  input wire logic psel,                          // apb select
  input wire logic penable,                       // apb access
  input wire logic pready,                        // apb ready
  input wire logic pslverr,                       // apb error
  input wire logic [ADDR_W-1:0] flashAddr,        // flash address
  input wire logic [DATA_W-1:0] flashDataOut,     // flash data out
  input wire logic flashDataOe_b,                 // data drive, low
  input wire logic flashCe_b,                     // chip enable
  input wire logic flashOe_b,                     // output enable
  input wire logic flashWe_b                      // write enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  ready_one_a: assert property (pready |=> !pready) else $error("pready held too long");
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not one wait state");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  read_quiet_a: assert property (!flashOe_b |-> flashDataOe_b && flashWe_b)
    else $error("host drives data during a read");
  read_len_a: assert property ($fell(flashOe_b) |-> (!flashOe_b && !flashCe_b)[*8] ##1 flashOe_b)
    else $error("read strobe length wrong");
  read_gap_a: assert property ($rose(flashOe_b) |-> flashCe_b ##1 flashCe_b)
    else $error("no idle gap after read");
  wr_len_a: assert property ($fell(flashWe_b) |->
    (!flashWe_b && !flashCe_b && !flashDataOe_b)[*4] ##1 flashWe_b)
    else $error("write pulse length wrong");
  wr_hold_a: assert property ($rose(flashWe_b) |-> !flashDataOe_b && $stable(flashDataOut))
    else $error("write data not held");
  addr_hold_a: assert property (!flashCe_b && !$fell(flashCe_b) |-> $stable(flashAddr))
    else $error("address moved inside a cycle");

  read_seen_c: cover property ($fell(flashOe_b));
  write_seen_c: cover property ($fell(flashWe_b));
  err_seen_c: cover property (pslverr);
endmodule : flash_status_checker

bind flash_status_host flash_status_checker chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
  .flashDataOe_b(flashDataOe_b), .flashCe_b(flashCe_b), .flashOe_b(flashOe_b),
  .flashWe_b(flashWe_b)
);

`default_nettype wire

// ==== test/flash_status_host_bench.sv ====
`timescale 1ns/100ps
`default_nettype none

module flash_status_host_bench;
  import flash_status_pkg::*;
  localparam logic [7:0] ARR = 8'h3C;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [ADDR_W-1:0] flashAddr;
  logic [DATA_W-1:0] flashDataOut, flashDataIn;
  logic flashDataOe_b, flashCe_b, flashOe_b, flashWe_b;
  logic arm, failMode, eraseMode, resetSeen;
  logic [7:0] busyReads;
  int error_cnt, check_count;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  flash_status_host uut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flashAddr(flashAddr), .flashDataOut(flashDataOut),
    .flashDataOe_b(flashDataOe_b), .flashDataIn(flashDataIn), .flashCe_b(flashCe_b),
    .flashOe_b(flashOe_b), .flashWe_b(flashWe_b));
  flash_device_model dev (.flashAddr(flashAddr), .flashDataOut(flashDataOut),
    .flashCe_b(flashCe_b), .flashOe_b(flashOe_b), .flashWe_b(flashWe_b), .arm(arm),
    .busyReads(busyReads), .failMode(failMode), .eraseMode(eraseMode),
    .flashDataIn(flashDataIn), .resetSeen(resetSeen));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic hang(input string nm);
    error_cnt++;
    $display("BAD %s expected answer seen none", nm);
    give_verdict();
  endtask : hang

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) hang("apb ready");
  endtask : apb

  // abort is retried because it is ignored while a flash cycle is outstanding;
  // the odd retry period walks across the single open cycle between reads
  task automatic wait_idle(input logic abort);
    int n;
    n = 0;
    do begin
      if (abort) begin
        apb(1'b1, OFS_CTRL, 32'h0000_0008);
        @(posedge clk_sys);
      end
      apb(1'b0, OFS_STATUS, ZERO_WORD);
      n++;
    end while (rd[ST_BUSY] !== 1'b0 && n < 400);
    if (n >= 400) hang("idle wait");
  endtask : wait_idle

  task automatic launch(input logic [18:0] a, input logic [31:0] cmd);
    apb(1'b1, OFS_ADDR, {13'h0000, a});
    apb(1'b1, OFS_CTRL, cmd);
  endtask : launch

  task automatic rd_byte(input logic [18:0] a);
    launch(a, 32'h0000_0004);
    wait_idle(1'b0);
    apb(1'b0, OFS_RDATA, ZERO_WORD);
  endtask : rd_byte

  task automatic arm_dev(input logic [7:0] n, input logic f, input logic e);
    @(posedge clk_sys);
    busyReads <= n;
    failMode <= f;
    eraseMode <= e;
    arm <= 1'b1;
    @(posedge clk_sys);
    arm <= 1'b0;
  endtask : arm_dev

  task automatic t_regs();
    apb(1'b0, OFS_STATUS, ZERO_WORD);
    check("status reset", rd, ZERO_WORD);
    apb(1'b0, 12'h020, ZERO_WORD);
    check("unmapped err", {31'h0000_0000, er}, 32'h0000_0001);
    check("unmapped data", rd, ZERO_WORD);
    apb(1'b1, OFS_ADDR, 32'h0001_2345);
    apb(1'b0, OFS_ADDR, ZERO_WORD);
    check("addr reg", rd, 32'h0001_2345);
    $display("test regs done");
  endtask : t_regs

  task automatic t_pass();
    arm_dev(8'h05, 1'b0, 1'b0);
    launch(19'h0_1234, 32'h0000_0001);
    wait_idle(1'b0);
    check("pass status", rd, {16'h0000, ARR, 3'b001, ARR[3], 4'b0110});
    rd_byte(19'h0_1234);
    check("array after pass", rd, {24'h00_0000, ARR});
    $display("test pass done");
  endtask : t_pass

  task automatic t_fail();
    arm_dev(8'h00, 1'b1, 1'b0);
    launch(19'h0_0040, 32'h0000_0001);
    wait_idle(1'b0);
    check("fail flags", {28'h000_0000, rd[3:0]}, 32'h0000_000A);
    check("fail bit seen", {31'h0000_0000, rd[13]}, 32'h0000_0001);
    check("reset command", {31'h0000_0000, resetSeen}, 32'h0000_0001);
    rd_byte(19'h0_0040);
    check("array after reset", rd, {24'h00_0000, ARR});
    $display("test fail done");
  endtask : t_fail

  task automatic t_abort();
    arm_dev(8'h64, 1'b0, 1'b0);
    launch(19'h0_1234, 32'h0000_0001);
    apb(1'b1, OFS_ADDR, 32'h0000_0777);
    wait_idle(1'b1);
    check("no pass on abort", {31'h0000_0000, rd[ST_PASS]}, 32'h0000_0000);
    apb(1'b0, OFS_ADDR, ZERO_WORD);
    check("addr kept busy", rd, 32'h0000_1234);
    launch(19'h0_1234, 32'h0000_0001);
    wait_idle(1'b0);
    check("restart passes", {29'h0000_0000, rd[2:0]}, 32'h0000_0006);
    $display("test abort done");
  endtask : t_abort

  task automatic t_erase();
    arm_dev(8'h06, 1'b0, 1'b1);
    rd_byte(19'h2_0010);
    check("erase status", rd & 32'h0000_00BB, 32'h0000_0008);
    rd_byte(19'h5_0000);
    check("other sector", rd, {24'h00_0000, ARR});
    launch(19'h2_0010, 32'h0000_0011);
    wait_idle(1'b0);
    check("sector poll", {29'h0000_0000, rd[2:0]}, 32'h0000_0006);
    $display("test erase done");
  endtask : t_erase

  initial begin
    error_cnt = 0;
    check_count = 0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = ZERO_WORD;
    arm = 1'b0;
    busyReads = 8'h00;
    failMode = 1'b0;
    eraseMode = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_pass();
    t_fail();
    t_abort();
    t_erase();
    give_verdict();
  end
endmodule : flash_status_host_bench

`default_nettype wire

// ==== verilog/flash_cycle.sv ====
`timescale 1ns/100ps
`default_nettype none

module flash_cycle (
  input wire logic clk_sys,                                  // system clock
  input wire logic rst_b,                                    // synchronised reset, low
  input wire logic reqValid,                                 // start one bus cycle
  input wire flash_status_pkg::flash_req_t req,              // cycle kind, address, data
  output logic done,                                         // pulse: cycle finished
  output logic [flash_status_pkg::DATA_W-1:0] rdata,         // captured read byte
  output logic [flash_status_pkg::ADDR_W-1:0] flashAddr,     // address pins
  output logic [flash_status_pkg::DATA_W-1:0] flashDataOut,  // data pins, out
  output logic flashDataOe_b,                                // data pins, low drives
  input wire logic [flash_status_pkg::DATA_W-1:0] flashDataIn, // data pins, in
  output logic flashCe_b,                                    // chip enable, low
  output logic flashOe_b,                                    // output enable, low
  output logic flashWe_b                                     // write enable, low
);
  import flash_status_pkg::*;

  typedef enum logic [1:0] {C_IDLE, C_RLOW, C_WLOW, C_GAP} cyc_state_t;

  cyc_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [DATA_W-1:0] sync1_r, sync2_r;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt;
  logic doe_b_r, doe_b_nxt, ce_b_r, ce_b_nxt, oe_b_r, oe_b_nxt, we_b_r, we_b_nxt;
  logic done_r, done_nxt;

  // ----------------------------------------------------------------
  // pin sequencing
  // ----------------------------------------------------------------
  // the read low time covers the access time plus the two sync stages,
  // so the byte taken is one the device has held stable
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rdata_nxt = rdata_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    doe_b_nxt = doe_b_r;
    ce_b_nxt = ce_b_r;
    oe_b_nxt = oe_b_r;
    we_b_nxt = we_b_r;
    done_nxt = 1'b0;
    case (state_r)
      C_IDLE: begin
        if (reqValid) begin
          addr_nxt = req.addr;
          ce_b_nxt = 1'b0;
          if (req.we) begin
            dout_nxt = req.data;
            doe_b_nxt = 1'b0;
            we_b_nxt = 1'b0;
            cnt_nxt = CNT_W'(WP_CYC - 1);
            state_nxt = C_WLOW;
          end else begin
            oe_b_nxt = 1'b0;
            cnt_nxt = CNT_W'(RD_CYC + SYNC_CYC - 1);
            state_nxt = C_RLOW;
          end
        end
      end
      C_RLOW: begin
        if (cnt_r == '0) begin
          rdata_nxt = sync2_r;
          oe_b_nxt = 1'b1;
          ce_b_nxt = 1'b1;
          done_nxt = 1'b1;
          cnt_nxt = CNT_W'(OEH_CYC - 1);
          state_nxt = C_GAP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      C_WLOW: begin
        if (cnt_r == '0) begin
          we_b_nxt = 1'b1;
          ce_b_nxt = 1'b1;
          done_nxt = 1'b1;
          cnt_nxt = CNT_W'(WPH_CYC - 1);
          state_nxt = C_GAP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      C_GAP: begin
        if (cnt_r == '0) begin
          doe_b_nxt = 1'b1;
          state_nxt = C_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: state_nxt = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= C_IDLE;
      cnt_r <= '0;
      sync1_r <= '0;
      sync2_r <= '0;
      rdata_r <= '0;
      addr_r <= '0;
      dout_r <= '0;
      doe_b_r <= 1'b1;
      ce_b_r <= 1'b1;
      oe_b_r <= 1'b1;
      we_b_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sync1_r <= flashDataIn;
      sync2_r <= sync1_r;
      rdata_r <= rdata_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      doe_b_r <= doe_b_nxt;
      ce_b_r <= ce_b_nxt;
      oe_b_r <= oe_b_nxt;
      we_b_r <= we_b_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign rdata = rdata_r;
  assign flashAddr = addr_r;
  assign flashDataOut = dout_r;
  assign flashDataOe_b = doe_b_r;
  assign flashCe_b = ce_b_r;
  assign flashOe_b = oe_b_r;
  assign flashWe_b = we_b_r;

endmodule : flash_cycle

`default_nettype wire

// ==== verilog/flash_status_host.sv ====
// How it works
// RL1: start polling with two back-to-back full status reads, compare toggle bits.
// RL2: device stops toggling when done; next read returns array data.
// RL3: still toggling with failure bit high: recheck toggling once more.
// RL4: still toggling after recheck: report failure and write the reset command.
// RL5: polling resumed after leaving restarts at the first double read.
// RL6: device sets the failure bit when its internal pulse limit runs out.
// RL7: programming a 0 back to 1 halts and eventually sets the failure bit.
// RL8: after a failure the device shows status until reset is written.
// RL9: erase window bit is 0 during acceptance time-out, then 1; commands restart it.
// RL10: chip erase has no acceptance time-out or window bit.
// RL11: window check may be skipped only if sector commands come under 50 us apart.
// RL12: window bit 1 means erase began; only erase suspend is accepted.
// RL13: window bit 0 means more sector erase commands are still accepted.
// RL14: check the window bit before and after each extra sector erase command.
// RL15: confirm acceptance by polling before reading the window bit.
// RL16: during program, polling bit complements, primary toggles, failure 0, sector steady.
// RL17: read polling and sector toggle bits at a valid target address.
// RL18: during erase the polling bit reads 0 in selected sectors.
// RL19: erase done or suspended: polling bit 1, primary toggle stops.
// RL20: sector toggle bit toggles only inside sectors selected for erase.
// RL21: erase-suspend program toggles the primary bit until the program ends.
// RL22: in suspend, unselected sectors read back plain array data.
`timescale 1ns/100ps
`default_nettype none

module flash_status_host #(
  parameter logic [7:0] RESET_CMD = 8'hF0  // command byte that returns to array reads
) (
  input wire logic clk_sys,                                  // 100 MHz clock
  input wire logic rst_b,                                    // async reset, low
  input wire logic psel,                                     // apb select
  input wire logic penable,                                  // apb access phase
  input wire logic pwrite,                                   // apb direction
  input wire logic [11:0] paddr,                             // apb byte address
  input wire logic [31:0] pwdata,                            // apb write data
  output logic [31:0] prdata,                                // apb read data
  output logic pready,                                       // apb ready
  output logic pslverr,                                      // apb error, unmapped
  output logic [flash_status_pkg::ADDR_W-1:0] flashAddr,     // flash address pins
  output logic [flash_status_pkg::DATA_W-1:0] flashDataOut,  // flash data, out
  output logic flashDataOe_b,                                // flash data, low drives
  input wire logic [flash_status_pkg::DATA_W-1:0] flashDataIn, // flash data, in
  output logic flashCe_b,                                    // chip enable, low
  output logic flashOe_b,                                    // output enable, low
  output logic flashWe_b                                     // write enable, low
);
  import flash_status_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_RD1, S_RD2, S_RD3, S_RD4, S_RST, S_ONE} host_state_t;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rstMeta_r, rstSync_r;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  function automatic logic togBit(input logic sectorSel, input logic [DATA_W-1:0] b);
    togBit = sectorSel ? b[SECTOR_TOGGLE_BIT] : b[PRIMARY_TOGGLE_BIT];
  endfunction : togBit

  // ----------------------------------------------------------------
  // registers and polling sequencer
  // ----------------------------------------------------------------
  host_state_t state_r, state_nxt;
  logic pend_r, pend_nxt;
  logic [ADDR_W-1:0] addrReg_r, addrReg_nxt;
  logic [DATA_W-1:0] wdataReg_r, wdataReg_nxt;
  logic sectorSel_r, sectorSel_nxt;
  logic [DATA_W-1:0] first_r, first_nxt, last_r, last_nxt;
  logic done_r, done_nxt, pass_r, pass_nxt, fail_r, fail_nxt, polled_r, polled_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic cycReq;
  flash_req_t req;
  logic cycDone;
  logic [DATA_W-1:0] cycData;
  logic apbWr, apbRd, hit;
  logic [31:0] statusWord;

  assign apbWr = psel && penable && pwrite && !pready_r;
  assign apbRd = psel && penable && !pwrite && !pready_r;
  assign hit = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) || (paddr == OFS_WDATA)
      || (paddr == OFS_STATUS) || (paddr == OFS_RDATA);

  always_comb begin
    statusWord = ZERO_WORD;
    statusWord[ST_BUSY] = (state_r != S_IDLE);
    statusWord[ST_DONE] = done_r;
    statusWord[ST_PASS] = pass_r;
    statusWord[ST_FAIL] = fail_r;
    statusWord[ST_ERASE_WIN] = last_r[ERASE_WINDOW_BIT];  // [RL11] [RL14] [RL15]
    statusWord[ST_POLLED] = polled_r;
    statusWord[ST_LAST_LSB +: DATA_W] = last_r;
  end

  always_comb begin
    state_nxt = state_r;
    pend_nxt = pend_r;
    addrReg_nxt = addrReg_r;
    wdataReg_nxt = wdataReg_r;
    sectorSel_nxt = sectorSel_r;
    first_nxt = first_r;
    last_nxt = last_r;
    done_nxt = done_r;
    pass_nxt = pass_r;
    fail_nxt = fail_r;
    polled_nxt = polled_r;
    prdata_nxt = prdata_r;
    pready_nxt = psel && penable && !pready_r;
    pslverr_nxt = psel && penable && !pready_r && !hit;
    cycReq = 1'b0;
    req.we = 1'b0;
    req.addr = addrReg_r;  // [RL17]
    req.data = wdataReg_r;
    if (apbRd) begin
      case (paddr)
        OFS_ADDR: prdata_nxt = {{(32-ADDR_W){1'b0}}, addrReg_r};
        OFS_WDATA: prdata_nxt = {{(32-DATA_W){1'b0}}, wdataReg_r};
        OFS_STATUS: prdata_nxt = statusWord;
        OFS_RDATA: prdata_nxt = {{(32-DATA_W){1'b0}}, last_r};
        default: prdata_nxt = ZERO_WORD;
      endcase
    end
    if (apbWr && state_r == S_IDLE) begin
      if (paddr == OFS_ADDR) addrReg_nxt = pwdata[ADDR_W-1:0];
      if (paddr == OFS_WDATA) wdataReg_nxt = pwdata[DATA_W-1:0];
      if (paddr == OFS_CTRL) begin
        sectorSel_nxt = pwdata[CTRL_SECTOR_SEL];  // [RL20]
        if (pwdata[CTRL_POLL] || pwdata[CTRL_WRITE] || pwdata[CTRL_READ]) begin
          done_nxt = 1'b0;
          pass_nxt = 1'b0;
          fail_nxt = 1'b0;
          polled_nxt = 1'b0;
        end
        if (pwdata[CTRL_POLL]) state_nxt = S_RD1;  // [RL5]
        else if (pwdata[CTRL_WRITE] || pwdata[CTRL_READ]) begin
          first_nxt = {{(DATA_W-1){1'b0}}, pwdata[CTRL_WRITE]};
          state_nxt = S_ONE;
        end
      end
    end
    // an abort leaves the poll; the next poll begins at the double read
    if (apbWr && paddr == OFS_CTRL && pwdata[CTRL_ABORT] && state_r != S_IDLE
        && state_r != S_RST && !pend_r) begin
      state_nxt = S_IDLE;  // [RL5]
      done_nxt = 1'b1;
    end else if (state_r != S_IDLE) begin
      if (state_r == S_RST) begin
        req.we = 1'b1;
        req.data = RESET_CMD;  // [RL4] [RL8]
      end else if (state_r == S_ONE) begin
        req.we = first_r[0];
      end
      if (!pend_r) begin
        cycReq = 1'b1;
        pend_nxt = 1'b1;
      end else if (cycDone) begin
        pend_nxt = 1'b0;
        case (state_r)
          S_RD1: begin
            first_nxt = cycData;  // [RL1]
            state_nxt = S_RD2;
          end
          S_RD2: begin
            last_nxt = cycData;
            polled_nxt = 1'b1;
            if (togBit(sectorSel_r, cycData) == togBit(sectorSel_r, first_r)) begin
              pass_nxt = 1'b1;  // [RL1] [RL2] [RL19]
              done_nxt = 1'b1;
              state_nxt = S_IDLE;
            end else if (cycData[TIMEOUT_FAILURE_BIT]) begin
              state_nxt = S_RD3;  // [RL3] [RL6] [RL7]
            end else begin
              state_nxt = S_RD1;  // [RL5] [RL16] [RL18]
            end
          end
          S_RD3: begin
            first_nxt = cycData;  // [RL3]
            state_nxt = S_RD4;
          end
          S_RD4: begin
            last_nxt = cycData;
            if (togBit(sectorSel_r, cycData) == togBit(sectorSel_r, first_r)) begin
              pass_nxt = 1'b1;  // [RL3]
              done_nxt = 1'b1;
              state_nxt = S_IDLE;
            end else begin
              state_nxt = S_RST;  // [RL4]
            end
          end
          S_RST: begin
            fail_nxt = 1'b1;  // [RL4]
            done_nxt = 1'b1;
            state_nxt = S_IDLE;
          end
          S_ONE: begin
            if (!first_r[0]) last_nxt = cycData;  // [RL22]
            done_nxt = 1'b1;
            state_nxt = S_IDLE;
          end
          default: state_nxt = S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      state_r <= S_IDLE;
      pend_r <= 1'b0;
      addrReg_r <= '0;
      wdataReg_r <= '0;
      sectorSel_r <= 1'b0;
      first_r <= '0;
      last_r <= '0;
      done_r <= 1'b0;
      pass_r <= 1'b0;
      fail_r <= 1'b0;
      polled_r <= 1'b0;
      prdata_r <= ZERO_WORD;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pend_r <= pend_nxt;
      addrReg_r <= addrReg_nxt;
      wdataReg_r <= wdataReg_nxt;
      sectorSel_r <= sectorSel_nxt;
      first_r <= first_nxt;
      last_r <= last_nxt;
      done_r <= done_nxt;
      pass_r <= pass_nxt;
      fail_r <= fail_nxt;
      polled_r <= polled_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // flash bus cycles
  // ----------------------------------------------------------------
  flash_cycle u_cycle (
    .clk_sys(clk_sys),
    .rst_b(rstSync_r),
    .reqValid(cycReq),
    .req(req),
    .done(cycDone),
    .rdata(cycData),
    .flashAddr(flashAddr),
    .flashDataOut(flashDataOut),
    .flashDataOe_b(flashDataOe_b),
    .flashDataIn(flashDataIn),
    .flashCe_b(flashCe_b),
    .flashOe_b(flashOe_b),
    .flashWe_b(flashWe_b)
  );

endmodule : flash_status_host

`default_nettype wire

// ==== verilog/flash_status_pkg.sv ====
package flash_status_pkg;

  // ----------------------------------------------------------------
  // flash pin widths and status bit positions
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int DATA_POLLING_BIT = 7;
  localparam int PRIMARY_TOGGLE_BIT = 6;
  localparam int TIMEOUT_FAILURE_BIT = 5;
  localparam int ERASE_WINDOW_BIT = 3;
  localparam int SECTOR_TOGGLE_BIT = 2;

  // ----------------------------------------------------------------
  // timing, in ns and in clk_sys cycles (least times round up)
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_RC_NS = 55;
  localparam int T_OEH_NS = 10;
  localparam int T_WP_NS = 30;
  localparam int T_WPH_NS = 20;
  localparam int T_AH_NS = 40;
  localparam int SYNC_CYC = 2;
  localparam int RD_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int OEH_CYC = (T_OEH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_RAW = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int AH_CYC = (T_AH_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (WP_RAW > AH_CYC) ? WP_RAW : AH_CYC;
  localparam int WPH_CYC = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_ADDR = 12'h004;
  localparam logic [11:0] OFS_WDATA = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_RDATA = 12'h010;

  // ctrl bits (write one to launch or abort, self clearing; sector select is held)
  localparam int CTRL_POLL = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_READ = 2;
  localparam int CTRL_ABORT = 3;
  localparam int CTRL_SECTOR_SEL = 4;

  // status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_PASS = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_ERASE_WIN = 4;
  localparam int ST_POLLED = 5;
  localparam int ST_LAST_LSB = 8;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } flash_req_t;

endpackage : flash_status_pkg
